// *** ctw_core.sv ***
// Purpose: fetch, decode and execute of the test, wait and move group
// Assumes: memory answers mem_rdata combinationally for the current mem_addr
// Notes:   one bus access per clock; vectoring after wake-up is outside
// Notes on behaviour
// - test sets n/z, clears v, keeps rest
// - wait clears mask, halts until interrupt
// - stack short offset: sp plus byte
// - stack wide offset: sp plus high-first word
// - index plus byte, then index increments
// - direct read, write at index, increment
// - immediate byte stored at direct address
// - read at index, increment, store direct
// - direct source then direct destination copy
// - two address bytes, high byte first
// - index plus high-first wide offset
// - index used directly, no offset fetched
// - index used, incremented after access
// - signed offset added when condition holds
`timescale 1ns/1ps
`default_nettype none
module ctw_core #(
  parameter logic [15:0] RESET_PC = ctw_pkg::RESET_PC  // first fetch address
) (
  input  wire logic        clk_sys,    // core clock, 20 MHz
  input  wire logic        rst_n,      // synchronous reset, active low
  output logic [15:0]      mem_addr,   // bus address
  output logic             mem_rd,     // read strobe
  output logic             mem_wr,     // write strobe
  output logic [7:0]       mem_wdata,  // write data
  input  wire logic [7:0]  mem_rdata,  // read data for mem_addr
  input  wire logic        irq_req,    // interrupt request, same clock
  output logic             halted,     // core stopped by wait
  output logic [7:0]       acc,        // accumulator
  output logic [15:0]      index_hx,   // 16-bit index register
  output logic [15:0]      stack_ptr,  // stack pointer
  output logic [15:0]      prog_ctr,   // program counter
  output logic             flag_v,     // overflow
  output logic             flag_h,     // half-carry
  output logic             flag_i,     // interrupt mask
  output logic             flag_n,     // negative
  output logic             flag_z,     // zero
  output logic             flag_c      // carry
);

  //////////////////////////////////////////////////////////////////////////////
  // sequencer states
  typedef enum logic [3:0] {
    S_FETCH,  // opcode read
    S_PRE,    // opcode after escape byte
    S_B1,     // first operand byte
    S_B2,     // second operand byte
    S_READ,   // operand read at ea
    S_DST,    // direct destination byte
    S_WRITE,  // destination write
    S_REL,    // branch offset byte
    S_HALT    // stopped until interrupt
  } ctw_state_t;

  ctw_state_t       state;       // current state
  ctw_state_t       next_state;  // next state
  ctw_pkg::ctw_dec_t dec;        // latched decode
  ctw_pkg::ctw_dec_t next_dec;   // decode of this fetch
  logic [15:0]      ea;          // operand address
  logic [15:0]      next_ea;     // next operand address
  logic [7:0]       data;        // moved or tested byte
  logic [7:0]       next_data;   // next byte
  logic [7:0]       hi;          // high byte of a wide field
  logic [7:0]       next_hi;     // next high byte
  logic             eq;          // branch condition
  logic             next_eq;     // next branch condition
  logic [15:0]      next_pc;     // next program counter
  logic [15:0]      next_hx;     // next index
  logic [7:0]       next_acc;    // next accumulator
  logic [15:0]      next_addr;   // next bus address
  logic             next_rd;     // next read strobe
  logic             next_wr;     // next write strobe
  logic [7:0]       next_wdata;  // next write data
  logic             upd_nz;      // flag update strobe
  logic [7:0]       nz_data;     // value tested
  logic             clr_i;       // clear mask strobe
  logic [15:0]      sext;        // sign-extended read byte
  logic [15:0]      wide_base;   // base for two-byte forms

  assign halted = (state == S_HALT);
  assign sext   = {{8{mem_rdata[7]}}, mem_rdata};

  //////////////////////////////////////////////////////////////////////////////
  // flag register
  ctw_flags u_flags (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .upd_nz  (upd_nz),
    .nz_data (nz_data),
    .clr_i   (clr_i),
    .flag_v  (flag_v),
    .flag_h  (flag_h),
    .flag_i  (flag_i),
    .flag_n  (flag_n),
    .flag_z  (flag_z),
    .flag_c  (flag_c)
  );

  // base register that a wide offset is added to
  always_comb begin
    case (dec.mode)
      ctw_pkg::M_IX2: wide_base = index_hx;
      ctw_pkg::M_SP2: wide_base = stack_ptr;
      default:        wide_base = 16'h0000;  // plain absolute address
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer: next state, bus request and register updates
  always_comb begin
    next_state = state;
    next_dec   = dec;
    next_ea    = ea;
    next_data  = data;
    next_hi    = hi;
    next_eq    = eq;
    next_pc    = prog_ctr;
    next_hx    = index_hx;
    next_acc   = acc;
    next_addr  = mem_addr;
    next_rd    = 1'b1;
    next_wr    = 1'b0;
    next_wdata = mem_wdata;
    upd_nz     = 1'b0;
    nz_data    = mem_rdata;
    clr_i      = 1'b0;
    case (state)
      S_FETCH, S_PRE: begin
        next_pc   = prog_ctr + ctw_pkg::ADDR_STEP;
        next_addr = prog_ctr + ctw_pkg::ADDR_STEP;
        if (state == S_FETCH && mem_rdata == ctw_pkg::OP_PREFIX) begin
          next_state = S_PRE;
        end else begin
          next_dec   = ctw_pkg::ctw_decode(state == S_PRE, mem_rdata);
          next_state = S_B1;
          case (next_dec.mode)
            ctw_pkg::M_INH: begin
              next_state = S_FETCH;
              if (next_dec.kind == ctw_pkg::K_WAIT) begin
                clr_i      = 1'b1;
                next_state = S_HALT;
                next_rd    = 1'b0;
              end else if (next_dec.kind == ctw_pkg::K_TST) begin
                upd_nz  = 1'b1;
                nz_data = (mem_rdata == ctw_pkg::OP_TST_X) ? index_hx[7:0] : acc;
              end
            end
            ctw_pkg::M_IX, ctw_pkg::M_IXP, ctw_pkg::M_IXPD: begin
              next_ea    = index_hx;
              next_addr  = index_hx;
              next_state = S_READ;
            end
            ctw_pkg::M_REL: begin
              next_eq    = flag_z;
              next_state = S_REL;
            end
            default: next_state = S_B1;
          endcase
        end
      end
      S_B1: begin
        next_pc    = prog_ctr + ctw_pkg::ADDR_STEP;
        next_addr  = prog_ctr + ctw_pkg::ADDR_STEP;
        next_state = S_READ;
        case (dec.mode)
          ctw_pkg::M_DIR, ctw_pkg::M_DD, ctw_pkg::M_DIXP: begin
            next_ea   = {ctw_pkg::DIR_PAGE, mem_rdata};
            next_addr = {ctw_pkg::DIR_PAGE, mem_rdata};
          end
          ctw_pkg::M_IX1, ctw_pkg::M_IX1P: begin
            next_ea   = index_hx + {8'h00, mem_rdata};
            next_addr = index_hx + {8'h00, mem_rdata};
          end
          ctw_pkg::M_SP1: begin
            next_ea   = stack_ptr + {8'h00, mem_rdata};
            next_addr = stack_ptr + {8'h00, mem_rdata};
          end
          ctw_pkg::M_EXT, ctw_pkg::M_IX2, ctw_pkg::M_SP2: begin
            next_hi    = mem_rdata;
            next_state = S_B2;
          end
          ctw_pkg::M_IMM: begin
            next_acc   = mem_rdata;
            upd_nz     = 1'b1;
            next_state = S_FETCH;
          end
          ctw_pkg::M_IMD: begin
            next_data  = mem_rdata;
            next_state = S_DST;
          end
          default: next_state = S_FETCH;
        endcase
      end
      S_B2: begin
        next_pc    = prog_ctr + ctw_pkg::ADDR_STEP;
        next_ea    = {hi, mem_rdata} + wide_base;
        next_addr  = {hi, mem_rdata} + wide_base;
        next_state = S_READ;
      end
      S_READ: begin
        next_data  = mem_rdata;
        next_addr  = prog_ctr;
        next_state = S_FETCH;
        case (dec.kind)
          ctw_pkg::K_TST: upd_nz = 1'b1;
          ctw_pkg::K_LDA: begin
            next_acc = mem_rdata;
            upd_nz   = 1'b1;
          end
          ctw_pkg::K_CBEQ: begin
            next_eq = (acc == mem_rdata);
            if (dec.mode == ctw_pkg::M_IX1P || dec.mode == ctw_pkg::M_IXP) begin
              next_hx = index_hx + ctw_pkg::ADDR_STEP;
            end
            next_state = S_REL;
          end
          ctw_pkg::K_MOV: begin
            if (dec.mode == ctw_pkg::M_DIXP) begin
              next_ea    = index_hx;
              next_addr  = index_hx;
              next_rd    = 1'b0;
              next_wr    = 1'b1;
              next_wdata = mem_rdata;
              next_state = S_WRITE;
            end else begin
              if (dec.mode == ctw_pkg::M_IXPD) begin
                next_hx = index_hx + ctw_pkg::ADDR_STEP;
              end
              next_state = S_DST;
            end
          end
          default: next_state = S_FETCH;
        endcase
      end
      S_DST: begin
        next_pc    = prog_ctr + ctw_pkg::ADDR_STEP;
        next_ea    = {ctw_pkg::DIR_PAGE, mem_rdata};
        next_addr  = {ctw_pkg::DIR_PAGE, mem_rdata};
        next_rd    = 1'b0;
        next_wr    = 1'b1;
        next_wdata = data;
        next_state = S_WRITE;
      end
      S_WRITE: begin
        // moved byte sets n/z like a test
        upd_nz  = 1'b1;
        nz_data = data;
        if (dec.mode == ctw_pkg::M_DIXP) begin
          next_hx = index_hx + ctw_pkg::ADDR_STEP;
        end
        next_addr  = prog_ctr;
        next_state = S_FETCH;
      end
      S_REL: begin
        next_pc = eq ? prog_ctr + ctw_pkg::ADDR_STEP + sext
                     : prog_ctr + ctw_pkg::ADDR_STEP;
        next_addr  = next_pc;
        next_state = S_FETCH;
      end
      S_HALT: begin
        next_rd = 1'b0;
        if (irq_req) begin
          next_rd    = 1'b1;
          next_addr  = prog_ctr;
          next_state = S_FETCH;
        end
      end
      default: next_state = S_FETCH;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= S_FETCH;
      dec   <= '{ctw_pkg::K_NOP, ctw_pkg::M_INH};
      ea    <= 16'h0000;
      data  <= 8'h00;
      hi    <= 8'h00;
      eq    <= 1'b0;
    end else begin
      state <= next_state;
      dec   <= next_dec;
      ea    <= next_ea;
      data  <= next_data;
      hi    <= next_hi;
      eq    <= next_eq;
    end
  end

  // programmer-visible registers; sp is never written by this group
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prog_ctr  <= RESET_PC;
      index_hx  <= ctw_pkg::RESET_HX;
      acc       <= ctw_pkg::RESET_ACC;
      stack_ptr <= ctw_pkg::RESET_SP;
    end else begin
      prog_ctr <= next_pc;
      index_hx <= next_hx;
      acc      <= next_acc;
    end
  end

  // bus outputs come from flops so the memory sees clean strobes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mem_addr  <= RESET_PC;
      mem_rd    <= 1'b1;
      mem_wr    <= 1'b0;
      mem_wdata <= 8'h00;
    end else begin
      mem_addr  <= next_addr;
      mem_rd    <= next_rd;
      mem_wr    <= next_wr;
      mem_wdata <= next_wdata;
    end
  end

endmodule // ctw_core
`default_nettype wire

// *** ctw_pkg.sv ***
// Purpose: shared opcodes, reset values and decode types for the test/wait core
// Assumes: byte-wide memory bus with 16-bit addresses
// Notes:   the decode function is used in the plain and the prefixed fetch cycle
`default_nettype none
package ctw_pkg;

  // opcodes of the test_sign_zero family
  localparam logic [7:0] OP_TST_DIR  = 8'h3D;
  localparam logic [7:0] OP_TST_A    = 8'h4D;
  localparam logic [7:0] OP_TST_X    = 8'h5D;
  localparam logic [7:0] OP_TST_IX1  = 8'h6D;
  localparam logic [7:0] OP_TST_IX   = 8'h7D;
  // escape byte that selects the stack-relative page
  localparam logic [7:0] OP_PREFIX   = 8'h9E;
  // wait: clear mask and halt
  localparam logic [7:0] OP_WAIT     = 8'h8F;
  // byte moves
  localparam logic [7:0] OP_MOV_DD   = 8'h4E;
  localparam logic [7:0] OP_MOV_DIXP = 8'h5E;
  localparam logic [7:0] OP_MOV_IMD  = 8'h6E;
  localparam logic [7:0] OP_MOV_IXPD = 8'h7E;
  // loads that exercise the remaining operand forms
  localparam logic [7:0] OP_LDA_IMM  = 8'hA6;
  localparam logic [7:0] OP_LDA_DIR  = 8'hB6;
  localparam logic [7:0] OP_LDA_EXT  = 8'hC6;
  localparam logic [7:0] OP_LDA_IX2  = 8'hD6;
  localparam logic [7:0] OP_LDA_IX1  = 8'hE6;
  localparam logic [7:0] OP_LDA_IX   = 8'hF6;
  // compare-and-branch with post increment, and a plain branch
  localparam logic [7:0] OP_CBEQ_IX1P = 8'h61;
  localparam logic [7:0] OP_CBEQ_IXP  = 8'h71;
  localparam logic [7:0] OP_BEQ       = 8'h27;

  // fixed values
  localparam logic [7:0]  DIR_PAGE    = 8'h00;
  localparam logic [15:0] ADDR_STEP   = 16'h0001;
  localparam logic [15:0] RESET_PC    = 16'h0000;
  localparam logic [15:0] RESET_SP    = 16'h00FF;
  localparam logic [15:0] RESET_HX    = 16'h0000;
  localparam logic [7:0]  RESET_ACC   = 8'h00;

  // operand forms
  typedef enum logic [3:0] {
    M_INH, M_IMM, M_DIR, M_EXT, M_IX, M_IX1, M_IX2, M_SP1, M_SP2,
    M_IXP, M_IX1P, M_DD, M_DIXP, M_IMD, M_IXPD, M_REL
  } ctw_mode_t;

  // operation classes
  typedef enum logic [2:0] {
    K_NOP, K_TST, K_LDA, K_CBEQ, K_MOV, K_BEQ, K_WAIT
  } ctw_kind_t;

  typedef struct packed {
    ctw_kind_t kind;
    ctw_mode_t mode;
  } ctw_dec_t;

  // opcode to operation and operand form; unknown codes act as no-ops
  function automatic ctw_dec_t ctw_decode(input logic pre, input logic [7:0] op);
    ctw_dec_t d;
    d = '{K_NOP, M_INH};
    if (pre) begin
      case (op)
        OP_TST_IX1:   d = '{K_TST, M_SP1};
        OP_LDA_IX1:   d = '{K_LDA, M_SP1};
        OP_LDA_IX2:   d = '{K_LDA, M_SP2};
        OP_CBEQ_IX1P: d = '{K_CBEQ, M_SP1};
        default:      d = '{K_NOP, M_INH};
      endcase
    end else begin
      case (op)
        OP_TST_DIR:   d = '{K_TST, M_DIR};
        OP_TST_A:     d = '{K_TST, M_INH};
        OP_TST_X:     d = '{K_TST, M_INH};
        OP_TST_IX1:   d = '{K_TST, M_IX1};
        OP_TST_IX:    d = '{K_TST, M_IX};
        OP_WAIT:      d = '{K_WAIT, M_INH};
        OP_MOV_DD:    d = '{K_MOV, M_DD};
        OP_MOV_DIXP:  d = '{K_MOV, M_DIXP};
        OP_MOV_IMD:   d = '{K_MOV, M_IMD};
        OP_MOV_IXPD:  d = '{K_MOV, M_IXPD};
        OP_LDA_IMM:   d = '{K_LDA, M_IMM};
        OP_LDA_DIR:   d = '{K_LDA, M_DIR};
        OP_LDA_EXT:   d = '{K_LDA, M_EXT};
        OP_LDA_IX2:   d = '{K_LDA, M_IX2};
        OP_LDA_IX1:   d = '{K_LDA, M_IX1};
        OP_LDA_IX:    d = '{K_LDA, M_IX};
        OP_CBEQ_IX1P: d = '{K_CBEQ, M_IX1P};
        OP_CBEQ_IXP:  d = '{K_CBEQ, M_IXP};
        OP_BEQ:       d = '{K_BEQ, M_REL};
        default:      d = '{K_NOP, M_INH};
      endcase
    end
    return d;
  endfunction

endpackage
`default_nettype wire

// *** ctw_flags.sv ***
// Purpose: condition flag register of the core
// Assumes: one update strobe for negative/zero, one for clearing the mask
// Notes:   half-carry and carry are held; nothing in this core alters them
`timescale 1ns/1ps
`default_nettype none
module ctw_flags (
  input  wire logic       clk_sys,  // core clock
  input  wire logic       rst_n,    // synchronous reset, active low
  input  wire logic       upd_nz,   // load n/z from nz_data and clear v
  input  wire logic [7:0] nz_data,  // value tested against zero
  input  wire logic       clr_i,    // clear the interrupt mask
  output logic            flag_v,   // overflow
  output logic            flag_h,   // half-carry
  output logic            flag_i,   // interrupt mask
  output logic            flag_n,   // negative
  output logic            flag_z,   // zero
  output logic            flag_c    // carry
);

  //////////////////////////////////////////////////////////////////////////////
  // overflow, negative and zero move together on a test result
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flag_v <= 1'b0;
      flag_n <= 1'b0;
      flag_z <= 1'b0;
    end else if (upd_nz) begin
      flag_v <= 1'b0;
      flag_n <= nz_data[7];
      flag_z <= (nz_data == 8'h00);
    end
  end

  // mask starts set so nothing interrupts before software allows it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flag_i <= 1'b1;
    end else if (clr_i) begin
      flag_i <= 1'b0;
    end
  end

  // held flags
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flag_h <= 1'b0;
      flag_c <= 1'b0;
    end
  end

endmodule // ctw_flags
`default_nettype wire

// *** ctw_core_assertions.sv ***
// Purpose: concurrent checks on the ports of the test/wait core
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to every instance of the core
`timescale 1ns/1ps
`default_nettype none
module ctw_core_assertions (
  input wire logic        clk_sys,    // core clock
  input wire logic        rst_n,      // synchronous reset, active low
  input wire logic [15:0] mem_addr,   // bus address
  input wire logic        mem_rd,     // read strobe
  input wire logic        mem_wr,     // write strobe
  input wire logic [7:0]  mem_wdata,  // write data
  input wire logic [7:0]  mem_rdata,  // read data
  input wire logic        irq_req,    // interrupt request
  input wire logic        halted,     // stopped by wait
  input wire logic [7:0]  acc,        // accumulator
  input wire logic [15:0] index_hx,   // index register
  input wire logic [15:0] stack_ptr,  // stack pointer
  input wire logic [15:0] prog_ctr,   // program counter
  input wire logic        flag_v,     // overflow
  input wire logic        flag_h,     // half-carry
  input wire logic        flag_i,     // interrupt mask
  input wire logic        flag_n,     // negative
  input wire logic        flag_z,     // zero
  input wire logic        flag_c      // carry
);
  // all checks share the core clock and its reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // named steps of the stop and wake sequence
  sequence s_halt_entry;
    $rose(halted);
  endsequence
  sequence s_wake;
    halted && irq_req;
  endsequence
  // a write cycle; the fetch of the next opcode must follow it
  sequence s_write;
    mem_wr && !mem_rd;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // stop caused by wait, wake-up, flag, index and write checks
  chk_halt_cause: assert property (s_halt_entry |-> $past(mem_rdata) == 8'h8F && !flag_i)
    else $error("stop entered without wait opcode or with mask set");
  chk_wait_flags: assert property (s_halt_entry |-> $stable(flag_n) && $stable(flag_z))
    else $error("wait altered negative or zero");
  chk_halt_holds: assert property (halted && !irq_req |=> halted)
    else $error("core left stop without an interrupt");
  chk_halt_quiet: assert property (halted |-> !mem_rd && !mem_wr)
    else $error("bus access while stopped");
  chk_wake_fetch: assert property (s_wake |=> !halted && mem_rd)
    else $error("no fetch after interrupt in stop");
  chk_mask_fall: assert property ($fell(flag_i) |-> halted)
    else $error("mask cleared without stopping");
  chk_hc_held: assert property ($stable(flag_h) && $stable(flag_c))
    else $error("half-carry or carry changed");
  chk_v_clear: assert property (($changed(flag_n) || $changed(flag_z)) |-> !flag_v)
    else $error("overflow set after flag update");
  chk_index_step: assert property ($changed(index_hx) |-> index_hx == $past(index_hx) + 16'h0001)
    else $error("index register changed by other than one");
  chk_write_once: assert property (s_write |=> !mem_wr && mem_rd)
    else $error("write strobe longer than one cycle");
endmodule // ctw_core_assertions

bind ctw_core ctw_core_assertions ctw_core_assertions_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .mem_addr(mem_addr), .mem_rd(mem_rd),
  .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .irq_req(irq_req),
  .halted(halted), .acc(acc), .index_hx(index_hx), .stack_ptr(stack_ptr),
  .prog_ctr(prog_ctr), .flag_v(flag_v), .flag_h(flag_h), .flag_i(flag_i),
  .flag_n(flag_n), .flag_z(flag_z), .flag_c(flag_c)
);
`default_nettype wire

// *** ctw_mem_model.sv ***
// Purpose: program and data memory on the far side of the core's bus
// Assumes: read data is combinational for the current address
// Notes:   filled with the wait opcode so a runaway core stops
`timescale 1ns/1ps
`default_nettype none
module ctw_mem_model (
  input  wire logic        clk_sys,    // core clock
  input  wire logic [15:0] mem_addr,   // bus address
  input  wire logic        mem_rd,     // read strobe
  input  wire logic        mem_wr,     // write strobe
  input  wire logic [7:0]  mem_wdata,  // write data
  output logic      [7:0]  mem_rdata   // read data
);
  logic [7:0] mem [0:65535];  // whole address space
  logic [7:0] last_q = 8'h00; // last byte read

  // fill with the wait opcode
  initial for (int k = 0; k < 65536; k++) mem[k] = 8'h8F;

  // unselected bus shows the inverse, so stale data cannot pass as valid
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;

  // write port and remembered read value
  always @(posedge clk_sys) begin
    if (mem_wr) mem[mem_addr] <= mem_wdata;
    if (mem_rd) last_q <= mem[mem_addr];
  end
endmodule // ctw_mem_model
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench for the test/wait core
// Assumes: program at 0400, data preloaded in the memory model
// Notes:   each group ends in a wait; an interrupt starts the next group
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys = 1'b0;                    // 20 MHz clock
  logic        rst_n = 1'b0;                      // reset, active low
  logic        irq_req = 1'b0;                    // wake request
  logic [15:0] mem_addr, index_hx, stack_ptr, prog_ctr;
  logic        mem_rd, mem_wr, halted;
  logic [7:0]  mem_wdata, mem_rdata, acc;
  logic        flag_v, flag_h, flag_i, flag_n, flag_z, flag_c;
  int          n_errors = 0;                      // mismatches
  int          checks_done = 0;                   // comparisons
  logic [15:0] ld_ptr = 16'h0401;                 // next free program byte
  // data bytes: address, value
  logic [23:0] pokes [14] = '{24'h3412A5, 24'h12345A, 24'h003080, 24'h004080, 24'h0000FF,
    24'h010F00, 24'h000181, 24'h20023C, 24'h011F11, 24'h01FF22, 24'h000233, 24'h001244,
    24'h002244, 24'h000355};

  // clock
  always #25 clk_sys = ~clk_sys;

  ctw_core #(.RESET_PC(16'h0400)) ctw_core_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .irq_req(irq_req),
    .halted(halted), .acc(acc), .index_hx(index_hx), .stack_ptr(stack_ptr),
    .prog_ctr(prog_ctr), .flag_v(flag_v), .flag_h(flag_h), .flag_i(flag_i),
    .flag_n(flag_n), .flag_z(flag_z), .flag_c(flag_c));

  ctw_mem_model ctw_mem_model_i (
    .clk_sys(clk_sys), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic end_of_test();
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // flags as v h i n z c
  function automatic logic [15:0] flags_now();
    return {10'h000, flag_v, flag_h, flag_i, flag_n, flag_z, flag_c};
  endfunction

  // count running cycles until stopped; bounded
  task automatic wait_halt(output int cyc);
    cyc = 0;
    #1;
    while (halted !== 1'b1) begin
      cyc++;
      if (cyc > 100) begin
        n_errors++;
        $display("unexpected at %0t: core never stopped", $time);
        end_of_test();
      end
      @(posedge clk_sys);
      #1;
    end
  endtask

  // row: len, five code bytes, cycles, a, b, c; code is followed by a wait
  task automatic run_row(input logic [79:0] r, output int cyc);
    for (int k = 0; k < 5; k++) ctw_mem_model_i.mem[ld_ptr + 16'(k)] = r[71 - 8 * k -: 8];
    ctw_mem_model_i.mem[ld_ptr + 16'(r[79:72])] = 8'h8F;
    ld_ptr = ld_ptr + 16'(r[79:72]) + 16'h0001;
    @(posedge clk_sys) irq_req <= 1'b1;
    @(posedge clk_sys) irq_req <= 1'b0;
    wait_halt(cyc);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // stopped core ignores time without interrupt
  task automatic sc_wait_hold();
    repeat (6) @(posedge clk_sys);
    #1;
    check({15'h0000, halted}, 16'h0001, "still stopped");
    check({15'h0000, mem_rd}, 16'h0000, "no read in stop");
    check(flags_now(), 16'h0000, "mask cleared by wait");
  endtask

  // every test form; flags alternate so a missed update shows
  task automatic sc_test_forms();
    logic [79:0] rows [6];
    int cyc;
    rows = '{80'h03_9E6D100000_05_02_00_00, 80'h01_7D00000000_03_04_00_00,
             80'h01_5D00000000_02_02_00_00, 80'h02_3D30000000_04_04_00_00,
             80'h01_4D00000000_02_02_00_00, 80'h02_6D40000000_04_04_00_00};
    foreach (rows[k]) begin
      run_row(rows[k], cyc);
      check(16'(cyc), {8'h00, rows[k][31:24]}, "test cycles");
      check(flags_now(), {8'h00, rows[k][23:16]}, "test flags");
    end
  endtask

  // the four byte moves, with index post increment
  task automatic sc_moves();
    logic [79:0] rows [4];
    logic [79:0] r;
    int cyc;
    rows = '{80'h03_6E77500000_05_50_77_00, 80'h03_4E50510000_06_51_77_00,
             80'h02_5E51000000_05_00_77_01, 80'h02_7E52000000_05_52_81_02};
    foreach (rows[k]) begin
      r = rows[k];
      run_row(r, cyc);
      check(16'(ctw_mem_model_i.mem[{8'h00, r[23:16]}]), {8'h00, r[15:8]}, "moved");
      check(index_hx, {8'h00, r[7:0]}, "index after move");
      check(16'(cyc), {8'h00, r[31:24]}, "move cycles");
      check({15'h0000, flag_n}, {15'h0000, r[15]}, "move sign");
    end
  endtask

  // operand address forms through loads
  task automatic sc_loads();
    logic [79:0] rows [6];
    int cyc;
    rows = '{80'h03_C612340000_05_5A_00_00, 80'h03_D620000000_05_3C_00_00,
             80'h03_9EE6200000_05_11_00_00, 80'h04_9ED6010000_06_22_00_00,
             80'h01_F600000000_03_33_00_00, 80'h02_E610000000_04_44_00_00};
    foreach (rows[k]) begin
      run_row(rows[k], cyc);
      check({8'h00, acc}, {8'h00, rows[k][23:16]}, "loaded byte");
      check(16'(cyc), {8'h00, rows[k][31:24]}, "load cycles");
    end
  endtask

  // compare and branch: taken skips a load, untaken runs it
  task automatic sc_branch();
    logic [79:0] rows [3];
    int cyc;
    // last row: equal-branch with zero clear must fall through into the load
    rows = '{80'h05_612002A699_00_44_00_03, 80'h04_7102A66600_00_66_00_04,
             80'h04_2702A67700_00_77_00_04};
    foreach (rows[k]) begin
      run_row(rows[k], cyc);
      check({8'h00, acc}, {8'h00, rows[k][23:16]}, "branch outcome");
      check(index_hx, {8'h00, rows[k][7:0]}, "index after branch");
    end
  endtask

  // reset while stopped returns the start state, then the core runs again from the start
  task automatic sc_reset();
    int cyc;
    @(posedge clk_sys) rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check(mem_addr, 16'h0400, "reset fetch address");
    check(stack_ptr, 16'h00FF, "reset stack");
    check(flags_now(), 16'h0008, "reset flags");
    check({15'h0000, halted}, 16'h0000, "reset ends stop");
    @(posedge clk_sys) rst_n <= 1'b1;
    wait_halt(cyc);
    check(16'(cyc), 16'h0001, "wait cycles after reset");
    check(prog_ctr, 16'h0401, "pc after wait");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int cyc;
    repeat (4) @(posedge clk_sys);
    for (int k = 0; k < 14; k++) ctw_mem_model_i.mem[pokes[k][23:8]] = pokes[k][7:0];
    rst_n <= 1'b1;
    wait_halt(cyc);
    sc_wait_hold();
    sc_test_forms();
    sc_moves();
    sc_loads();
    sc_branch();
    sc_reset();
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
